// file: rtl/wwdg_params.svh
`ifndef WWDG_PARAMS_SVH
`define WWDG_PARAMS_SVH

// register byte offsets
`define WWDG_OFS_CTRL 12'h000
`define WWDG_OFS_RELOAD 12'h004
`define WWDG_OFS_WINDOW 12'h008
`define WWDG_OFS_SERVICE 12'h00C
`define WWDG_OFS_COUNT 12'h010
`define WWDG_OFS_STATUS 12'h014
`define WWDG_OFS_MASK 12'h018

// control field positions
`define WWDG_CTRL_EN 0
`define WWDG_CTRL_SLOW 1
`define WWDG_CTRL_HALT 2
`define WWDG_CTRL_WINEN 3

// status field positions
`define WWDG_ST_WARN 0
`define WWDG_ST_WINERR 1
`define WWDG_ST_EXPIRE 2

// reset values
`define WWDG_CTRL_RST 4'h4
`define WWDG_RELOAD_RST 8'h00
`define WWDG_WINDOW_RST 8'h00
`define WWDG_MASK_RST 3'h0
`define WWDG_STATUS_RST 3'h0

// service key, divider counts, warning point, reset pulse length
`define WWDG_SERVICE_KEY 32'h0000A5C3
`define WWDG_DIV_FAST 7'h01
`define WWDG_DIV_SLOW 7'h7F
`define WWDG_WARN_CNT 16'hFF80
`define WWDG_RST_CYC 4'hF

`endif

// file: rtl/wwdg_pkg.sv
package wwdg_pkg;
    typedef enum logic [1:0] {
        WWDG_IDLE,
        WWDG_RUN,
        WWDG_FAIL
    } wwdg_state_e;

    typedef struct packed {
        logic win_en;
        logic halt;
        logic slow;
        logic en;
    } wwdg_ctrl_s;

    typedef struct packed {
        logic expire;
        logic winerr;
        logic warn;
    } wwdg_evt_s;
endpackage

// file: rtl/wwdg_top.sv
`include "wwdg_params.svh"
// Overview of operation
// - watchdog is disabled after reset; no counting and no reset output
// - when enabled and counter expires unserviced, system reset is forced
// - in debug mode halt bit stops counting; halt bit resets to one
// - 16-bit counter advances at pclk/2 or pclk/128, chosen by software
// - counter is two cascaded 8-bit halves; upper steps on lower wrap
// - service loads counter upper byte from the programmed reload value
// - service clears the counter lower byte to zero
// - programmable window boundary limits when a service is accepted
// - warning before overflow raises the non-maskable interrupt request
module wwdg_top #(
    // depth of the debug input synchroniser
    parameter int SYNC_STAGES = 2
) (
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // debug mode from core, asynchronous
    input wire logic debug_mode,
    // system side
    output logic sys_reset_req,
    output logic nmi_req,
    output logic irq
);

    wwdg_pkg::wwdg_state_e state_ff, nxt_state;
    wwdg_pkg::wwdg_ctrl_s ctrl_ff, nxt_ctrl;
    wwdg_pkg::wwdg_evt_s status_ff, nxt_status;
    wwdg_pkg::wwdg_evt_s mask_ff, nxt_mask;
    logic [7:0] reload_ff, nxt_reload;
    logic [7:0] window_ff, nxt_window;
    logic [7:0] cnt_lo_ff, nxt_cnt_lo;
    logic [7:0] cnt_hi_ff, nxt_cnt_hi;
    logic [6:0] div_ff, nxt_div;
    logic [3:0] rst_cnt_ff, nxt_rst_cnt;
    logic [SYNC_STAGES-1:0] dbg_sync_ff;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, pslverr_ff, nxt_pready, nxt_pslverr;
    logic sys_reset_ff, nmi_ff, irq_ff;
    logic nxt_sys_reset, nxt_nmi, nxt_irq;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a == o);
    endfunction

    // fewer stages would let a metastable level reach the counter
    if (SYNC_STAGES < 2) begin : g_sync_check
        $error("SYNC_STAGES must be two or more");
    end

    // bus decode: one wait state, write and read at the access cycle
    wire acc = psel && penable && !pready_ff;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire all_lanes = &pstrb;
    wire a_ctrl = hit(paddr, `WWDG_OFS_CTRL);
    wire a_reload = hit(paddr, `WWDG_OFS_RELOAD);
    wire a_window = hit(paddr, `WWDG_OFS_WINDOW);
    wire a_service = hit(paddr, `WWDG_OFS_SERVICE);
    wire a_count = hit(paddr, `WWDG_OFS_COUNT);
    wire a_status = hit(paddr, `WWDG_OFS_STATUS);
    wire a_mask = hit(paddr, `WWDG_OFS_MASK);
    wire mapped = a_ctrl | a_reload | a_window | a_service | a_count
        | a_status | a_mask;

    wire [15:0] count = {cnt_hi_ff, cnt_lo_ff};
    wire running = (state_ff == wwdg_pkg::WWDG_RUN);
    // halt only while debug is really active
    wire halted = ctrl_ff.halt && dbg_sync_ff[SYNC_STAGES-1];
    wire [6:0] div_top = ctrl_ff.slow ? `WWDG_DIV_SLOW
        : `WWDG_DIV_FAST;
    // >= so a slow to fast switch cannot skip a whole divider lap
    wire tick = running && !halted && (div_ff >= div_top);
    // a wrong key is no service; keeps a runaway store from feeding the dog
    wire service = wr && a_service && all_lanes
        && (pwdata == `WWDG_SERVICE_KEY);
    wire early = ctrl_ff.win_en && (cnt_hi_ff < window_ff);
    wire svc_ok = running && service && !early;
    wire svc_bad = running && service && early;
    wire lo_wrap = tick && (cnt_lo_ff == 8'hFF);
    wire expire = lo_wrap && (cnt_hi_ff == 8'hFF);
    wire warn_hit = tick
        && (count == (`WWDG_WARN_CNT - 16'h0001));
    wire [7:0] ctrl_rd = {4'h0, ctrl_ff};
    wire [7:0] st_rd = {5'h00, status_ff};
    wire [7:0] mask_rd = {5'h00, mask_ff};
    wire [31:0] rd_mux = a_ctrl ? {24'h000000, ctrl_rd}
        : a_reload ? {24'h000000, reload_ff}
        : a_window ? {24'h000000, window_ff}
        : a_count ? {16'h0000, count}
        : a_status ? {24'h000000, st_rd}
        : a_mask ? {24'h000000, mask_rd}
        : 32'h00000000;

    wwdg_pkg::wwdg_evt_s evt;
    assign evt.warn = warn_hit;
    assign evt.winerr = svc_bad;
    assign evt.expire = expire;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            wwdg_pkg::WWDG_IDLE: begin
                if (ctrl_ff.en) begin
                    nxt_state = wwdg_pkg::WWDG_RUN;
                end
            end
            wwdg_pkg::WWDG_RUN: begin
                if (expire || svc_bad) begin
                    nxt_state = wwdg_pkg::WWDG_FAIL;
                end else if (!ctrl_ff.en) begin
                    nxt_state = wwdg_pkg::WWDG_IDLE;
                end
            end
            wwdg_pkg::WWDG_FAIL: begin
                // reset pulse runs out, then back to the disabled state
                if (rst_cnt_ff == 4'h0) begin
                    nxt_state = wwdg_pkg::WWDG_IDLE;
                end
            end
            default: nxt_state = wwdg_pkg::WWDG_IDLE;
        endcase
    end

    always_comb begin
        nxt_div = div_ff;
        if (!running || halted || tick) begin
            nxt_div = 7'h00;
        end else begin
            nxt_div = div_ff + 7'h01;
        end
    end

    always_comb begin
        nxt_cnt_lo = cnt_lo_ff;
        nxt_cnt_hi = cnt_hi_ff;
        if (svc_ok || (state_ff == wwdg_pkg::WWDG_IDLE)) begin
            nxt_cnt_hi = reload_ff;
            nxt_cnt_lo = 8'h00;
        end else if (tick) begin
            nxt_cnt_lo = cnt_lo_ff + 8'h01;
            if (lo_wrap) begin
                nxt_cnt_hi = cnt_hi_ff + 8'h01;
            end
        end
    end

    always_comb begin
        nxt_rst_cnt = rst_cnt_ff;
        if (state_ff == wwdg_pkg::WWDG_FAIL) begin
            if (rst_cnt_ff != 4'h0) begin
                nxt_rst_cnt = rst_cnt_ff - 4'h1;
            end
        end else begin
            nxt_rst_cnt = `WWDG_RST_CYC;
        end
    end

    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_reload = reload_ff;
        nxt_window = window_ff;
        nxt_mask = mask_ff;
        if (wr && pstrb[0]) begin
            if (a_ctrl) begin
                nxt_ctrl = pwdata[3:0];
            end
            if (a_reload) begin
                nxt_reload = pwdata[7:0];
            end
            if (a_window) begin
                nxt_window = pwdata[7:0];
            end
            if (a_mask) begin
                nxt_mask = pwdata[2:0];
            end
        end
        // a failure drops the enable so the dog stays off after the reset
        if (state_ff == wwdg_pkg::WWDG_FAIL) begin
            nxt_ctrl.en = 1'b0;
        end
    end

    // write one to clear; a new event in the same cycle wins
    wire [2:0] clr = (wr && pstrb[0] && a_status) ? pwdata[2:0] : 3'h0;
    wire [2:0] evt_bits = evt;
    wire [2:0] old_bits = status_ff;
    logic [2:0] nxt_st_bits;
    for (genvar gb = 0; gb < 3; gb++) begin : g_sticky
        assign nxt_st_bits[gb] = evt_bits[gb]
            | (old_bits[gb] & ~clr[gb]);
    end
    assign nxt_status = nxt_st_bits;

    assign nxt_pready = acc;
    assign nxt_pslverr = acc && !mapped;
    assign nxt_prdata = rd ? rd_mux : 32'h00000000;
    assign nxt_sys_reset = (nxt_state == wwdg_pkg::WWDG_FAIL);
    // warning feeds the nmi line for as long as the flag stands
    assign nxt_nmi = nxt_status.warn;
    assign nxt_irq = |(nxt_status & nxt_mask);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= wwdg_pkg::WWDG_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // halt bit comes up set, so a debugger never trips the dog
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `WWDG_CTRL_RST;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_ff <= `WWDG_RELOAD_RST;
        end else begin
            reload_ff <= nxt_reload;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            window_ff <= `WWDG_WINDOW_RST;
        end else begin
            window_ff <= nxt_window;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_ff <= `WWDG_MASK_RST;
        end else begin
            mask_ff <= nxt_mask;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_ff <= `WWDG_STATUS_RST;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // both halves move on one edge so a read never sees a torn count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_lo_ff <= 8'h00;
            cnt_hi_ff <= 8'h00;
        end else begin
            cnt_lo_ff <= nxt_cnt_lo;
            cnt_hi_ff <= nxt_cnt_hi;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= 7'h00;
        end else begin
            div_ff <= nxt_div;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt_ff <= `WWDG_RST_CYC;
        end else begin
            rst_cnt_ff <= nxt_rst_cnt;
        end
    end

    // only the last stage is read; the pin is asynchronous
    for (genvar gs = 0; gs < SYNC_STAGES; gs++) begin : g_sync
        wire stage_in;
        if (gs == 0) begin : g_pin
            assign stage_in = debug_mode;
        end else begin : g_chain
            assign stage_in = dbg_sync_ff[gs - 1];
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                dbg_sync_ff[gs] <= 1'b0;
            end else begin
                dbg_sync_ff[gs] <= stage_in;
            end
        end
    end

    // bus answer, one cycle wide
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // system lines registered so no decode glitch reaches them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_reset_ff <= 1'b0;
            nmi_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            sys_reset_ff <= nxt_sys_reset;
            nmi_ff <= nxt_nmi;
            irq_ff <= nxt_irq;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign sys_reset_req = sys_reset_ff;
    assign nmi_req = nmi_ff;
    assign irq = irq_ff;

endmodule

// file: test/wwdg_top_asserts.sv
`include "wwdg_params.svh"
module wwdg_top_asserts (
    // apb side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // system side
    input wire logic debug_mode,
    input wire logic sys_reset_req,
    input wire logic nmi_req,
    input wire logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic en_seen_ff;
    wire wr_on = psel && penable && pwrite && pstrb[0];
    wire st_clr = wr_on && paddr == `WWDG_OFS_STATUS && pwdata[0];
    wire en_wr = wr_on && paddr == `WWDG_OFS_CTRL && pwdata[0];
    // sticky: only the first enable matters here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_seen_ff <= 1'b0;
        end else if (en_wr) begin
            en_seen_ff <= 1'b1;
        end
    end
    sequence s_take;
        psel && penable && !pready;
    endsequence
    property p_ans; s_take |=> pready; endproperty
    property p_pulse; pready |=> !pready; endproperty
    property p_err; pslverr |-> pready; endproperty
    property p_idle; !pready |-> prdata == 32'h0; endproperty
    property p_unm; pready && paddr > 12'h018 |-> pslverr; endproperty
    property p_rst16;
        $fell(sys_reset_req) |->
            $past(sys_reset_req, 16) && !$past(sys_reset_req, 17);
    endproperty
    property p_nmi;
        $fell(nmi_req) |-> $past(st_clr) || $past(st_clr, 2);
    endproperty
    property p_off;
        !en_seen_ff |-> !sys_reset_req && !nmi_req && !irq;
    endproperty
    a_ans: assert property (p_ans) else $error("ready late");
    a_pulse: assert property (p_pulse) else $error("ready too long");
    a_err: assert property (p_err) else $error("error without ready");
    a_idle: assert property (p_idle) else $error("read data not zero");
    a_unm: assert property (p_unm) else $error("unmapped not refused");
    a_rst16: assert property (p_rst16) else $error("reset pulse length");
    a_nmi: assert property (p_nmi) else $error("warning not sticky");
    a_off: assert property (p_off) else $error("active before enable");
endmodule

// file: test/tb.sv
`include "wwdg_params.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    bad_count++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, debug_mode, err;
    logic pready, pslverr, sys_reset_req, nmi_req, irq;
    logic [11:0] paddr;
    logic [3:0] pstrb;
    logic [31:0] pwdata, prdata, rd, c1;
    logic [7:0] r;
    int bad_count, cmp_count, n;
    wwdg_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .debug_mode(debug_mode), .sys_reset_req(sys_reset_req),
        .nmi_req(nmi_req), .irq(irq));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    function automatic int ticks(int cyc, logic slow);
        return slow ? cyc / 128 : cyc / 2;
    endfunction
    task finish_test;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // master holds everything until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input int d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) bad_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rate(input int cyc, input int lo, input int hi);
        apb(0, `WWDG_OFS_COUNT, 0);
        c1 = rd;
        repeat (cyc) @(posedge pclk);
        apb(0, `WWDG_OFS_COUNT, 0);
        `CHK("rate", 1'b1, rd - c1 >= lo && rd - c1 <= hi)
    endtask
    task automatic wait_rst(input int lim);
        n = 0;
        while (sys_reset_req !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask
    initial begin
        {psel, penable, pwrite, debug_mode, presetn} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        void'($urandom(53607));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `WWDG_OFS_CTRL, 0);
        `CHK("ctrl", 32'h4, rd)
        apb(0, 12'h020, 0);
        `CHK("unmapped", 1'b1, err)
        $display("test reset done");
        r = 8'($urandom_range(200, 16));
        apb(1, `WWDG_OFS_RELOAD, r);
        apb(1, `WWDG_OFS_CTRL, 32'h5);
        rate(600, ticks(600, 0), ticks(600, 0) + 3);
        `CHK("cascade", r + 8'h01, rd[15:8])
        apb(1, `WWDG_OFS_SERVICE, 32'h1234);
        pstrb <= 4'h7;
        apb(1, `WWDG_OFS_SERVICE, `WWDG_SERVICE_KEY);
        pstrb <= 4'hF;
        apb(0, `WWDG_OFS_COUNT, 0);
        `CHK("badkey", r + 8'h01, rd[15:8])
        r = 8'($urandom_range(200, 16));
        apb(1, `WWDG_OFS_RELOAD, r);
        apb(1, `WWDG_OFS_SERVICE, `WWDG_SERVICE_KEY);
        apb(0, `WWDG_OFS_COUNT, 0);
        `CHK("svc_hi", r, rd[15:8])
        `CHK("svc_lo", 1'b1, rd[7:0] <= 8'h03)
        apb(1, `WWDG_OFS_CTRL, 32'h7);
        rate(1280, ticks(1280, 1) - 1, ticks(1280, 1) + 1);
        apb(1, `WWDG_OFS_CTRL, 32'h5);
        debug_mode <= 1'b1;
        repeat (4) @(posedge pclk);
        rate(300, 0, 0);
        apb(1, `WWDG_OFS_CTRL, 32'h1);
        rate(300, ticks(300, 0), ticks(300, 0) + 3);
        debug_mode <= 1'b0;
        $display("test count done");
        apb(1, `WWDG_OFS_RELOAD, 32'hFF);
        for (int i = 0; i < 4; i++) begin
            apb(1, `WWDG_OFS_SERVICE, `WWDG_SERVICE_KEY);
            wait_rst(300);
            `CHK("serviced", 0, sys_reset_req)
        end
        wait_rst(2000);
        // 512 cycles after the service, less the 300 already waited
        `CHK("expiry", 1'b1, n >= 210 && n <= 214)
        `CHK("nmi", 1'b1, nmi_req)
        apb(0, `WWDG_OFS_STATUS, 0);
        `CHK("status", 32'h5, rd)
        apb(1, `WWDG_OFS_MASK, 32'h1);
        @(posedge pclk);
        `CHK("irq_on", 1'b1, irq)
        apb(1, `WWDG_OFS_STATUS, 32'h7);
        repeat (2) @(posedge pclk);
        `CHK("irq_off", 2'b00, {irq, nmi_req})
        $display("test expiry done");
        apb(1, `WWDG_OFS_WINDOW, 32'h80);
        apb(1, `WWDG_OFS_RELOAD, 32'h90);
        apb(1, `WWDG_OFS_CTRL, 32'hD);
        apb(1, `WWDG_OFS_SERVICE, `WWDG_SERVICE_KEY);
        wait_rst(20);
        `CHK("in_window", 0, sys_reset_req)
        apb(1, `WWDG_OFS_RELOAD, 8'($urandom_range(127, 0)));
        apb(1, `WWDG_OFS_SERVICE, `WWDG_SERVICE_KEY);
        apb(1, `WWDG_OFS_SERVICE, `WWDG_SERVICE_KEY);
        wait_rst(20);
        `CHK("early", 1'b1, sys_reset_req)
        apb(0, `WWDG_OFS_STATUS, 0);
        `CHK("winerr", 1'b1, rd[1])
        $display("test window done");
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        `CHK("rst_out", 0, sys_reset_req)
        apb(0, `WWDG_OFS_CTRL, 0);
        `CHK("rst_ctrl", 32'h4, rd)
        $display("test reset again done");
        finish_test();
    end
    initial begin
        #1ms;
        bad_count++;
        finish_test();
    end
endmodule
bind wwdg_top wwdg_top_asserts u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .debug_mode(debug_mode),
    .sys_reset_req(sys_reset_req), .nmi_req(nmi_req), .irq(irq));
